/* File: asp_io_regs.svh */
// Offsets, field positions, reset values and timing counts of the slave I/O block.
`ifndef ASP_IO_REGS_SVH
`define ASP_IO_REGS_SVH

// Register byte addresses, decoded on address bits 11:0.
`define ASP_CTRL_ADDR      12'h000
`define ASP_STAT_ADDR      12'h004

// Control register fields.
`define ASP_CTRL_PWM_EN    0
`define ASP_CTRL_INV_IN    1
`define ASP_CTRL_EXT_ADDR  2
`define ASP_CTRL_B_SLAVE   3
`define ASP_CTRL_ADDR_LSB  8
`define ASP_CTRL_LOCK      16
`define ASP_CTRL_WMASK     32'h0000_1F0F
`define ASP_CTRL_RESET     32'h0000_0000

// Status register fields.
`define ASP_STAT_DATA_LSB  0
`define ASP_STAT_IN_LSB    2
`define ASP_STAT_PIN_LSB   4
`define ASP_STAT_PEND      6
`define ASP_STAT_DUTY0_LSB 8
`define ASP_STAT_DUTY1_LSB 10

// AXI response codes.
`define ASP_RESP_OKAY      2'h0
`define ASP_RESP_SLVERR    2'h2

// Telegram decode constants.
`define ASP_PRGM_ADDR      5'h00
`define ASP_PRGM_INFO      5'h1D

// Duty codes carried in parameter bits 1:0, and output reset levels.
`define ASP_DUTY_FULL      2'h3
`define ASP_DUTY_HALF      2'h1
`define ASP_DUTY_QUARTER   2'h2
`define ASP_DUTY_EIGHTH    2'h0
`define ASP_DATA_RESET     2'h3

// Timing: 125 Hz PWM period split into sixteen slots.
`define ASP_CLK_PERIOD_NS  25
`define ASP_PWM_PERIOD_NS  8000000
`define ASP_PWM_SLOTS      16

`endif

/* File: asp_io_pkg.sv */
// Types shared by the slave I/O block.
package asp_io_pkg;

    // Kind of master call seen on the decoded telegram port.
    typedef enum logic [1:0] {
        ASP_CALL_OTHER,
        ASP_CALL_DATA_EXCHANGE,
        ASP_CALL_WRITE_PARAMETER,
        ASP_CALL_PROGRAM
    } asp_call_t;

endpackage

/* File: asp_in_sync.sv */
// Two-stage synchroniser for the asynchronous data input pins.
`timescale 1ns/100ps
module asp_in_sync (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [1:0] pin_in,
    output logic      [1:0] sync_out
);
    logic [1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_q   <= 2'h0;
            sync_out <= 2'h0;
        end else begin
            meta_q   <= pin_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* File: asp_pwm_chan.sv */
// One data output pin with its duty gating.
`include "asp_io_regs.svh"
`timescale 1ns/100ps
module asp_pwm_chan (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       pwm_en,
    input  wire logic [1:0] duty,
    input  wire logic [3:0] phase,
    input  wire logic       data_bit,
    output logic            pin_q
);
    logic on_phase;

    // Number of lit slots out of sixteen for a duty code.
    function automatic logic [4:0] on_slots(input logic [1:0] code);
        case (code)
            `ASP_DUTY_FULL:    on_slots = 5'h10;
            `ASP_DUTY_HALF:    on_slots = 5'h08;
            `ASP_DUTY_QUARTER: on_slots = 5'h04;
            default:           on_slots = 5'h02;
        endcase
    endfunction

    assign on_phase = !pwm_en || ({1'b0, phase} < on_slots(duty));

    // low means lit; high data stays high whatever the duty.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pin_q <= 1'b1;
        end else begin
            pin_q <= data_bit | ~on_phase;
        end
    end
endmodule

/* File: asp_io_top.sv */
// Data I/O port logic of an interface slave: data exchange, input, PWM.
// Notes on behaviour
// - In extended mode the select bit chooses A-slave or B-slave identity.
// - Program-mode call only works until the lock flag is set, then ignored.
// - Data exchange drops information bits 3 and 2.
// - Output pin 0 carries info bit 0, pin 1 carries info bit 1.
// - Data exchange response has bits 1:0 zero, inputs in bits 3:2.
// - Invert flag inverts each sampled input in the response.
// - Inputs sampled between request end bit and response start bit end.
// - Output pins change within that same sampling window.
// - Outputs modulated only while the PWM-enable flag is set.
// - Parameter bits 1:0 pick 16,8,4,2 of 16 slots; bit 2 picks output.
// - New duty takes effect only after the response has been sent.
// - After initialisation both duties are full.
// - Output pin is driven low during the on portion of a period.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`include "asp_io_regs.svh"
`timescale 1ns/100ps
module asp_io_top #(
    parameter int PWM_SLOT_CYCLES =
        `ASP_PWM_PERIOD_NS / `ASP_CLK_PERIOD_NS / `ASP_PWM_SLOTS
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic      [1:0]  s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    input  wire logic        call_valid,
    input  wire logic        call_ctrl_bit,
    input  wire logic [4:0]  call_addr,
    input  wire logic [4:0]  call_info,
    input  wire logic        resp_sent,
    output logic             resp_valid,
    output logic      [3:0]  resp_info,
    output logic             prog_mode_pulse,
    input  wire logic        data_input_pin_2,
    input  wire logic        data_input_pin_3,
    output logic             data_output_pin_0,
    output logic             data_output_pin_1
);
    logic [31:0]          ctrl_q;
    logic                 lock_q;
    logic                 aw_held_q;
    logic [11:0]          aw_addr_q;
    logic                 w_held_q;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;
    logic                 aw_have;
    logic                 w_have;
    logic [11:0]          wr_addr;
    logic [31:0]          wr_data;
    logic [3:0]           wr_strb;
    logic                 do_write;
    logic [31:0]          byte_mask;
    logic [31:0]          stat_word;
    logic [1:0]           in_sync;
    logic [1:0]           data_q;
    logic [1:0]           duty0_q;
    logic [1:0]           duty1_q;
    logic                 pend_q;
    logic                 pend_sel_q;
    logic [1:0]           pend_duty_q;
    logic                 resp_dx_q;
    logic [14:0]          slot_cnt_q;
    logic [3:0]           phase_q;
    logic                 pwm_en;
    logic                 inv_in;
    asp_io_pkg::asp_call_t call_kind;
    logic                 dx_hit;
    logic                 wp_hit;

    assign pwm_en = ctrl_q[`ASP_CTRL_PWM_EN];
    assign inv_in = ctrl_q[`ASP_CTRL_INV_IN];

    // Address match for calls whose information bit 3 carries inverted select.
    function automatic logic addr_hit(input logic [4:0] addr,
                                      input logic [4:0] info,
                                      input logic [31:0] ctrl);
        logic sel;
        sel = ~info[3];
        addr_hit = (addr == ctrl[`ASP_CTRL_ADDR_LSB +: 5]) &&
                   (!ctrl[`ASP_CTRL_EXT_ADDR] ||
                    (sel == ctrl[`ASP_CTRL_B_SLAVE]));
    endfunction

    // Classify the call from control bit and information bit 4.
    always_comb begin
        call_kind = asp_io_pkg::ASP_CALL_OTHER;
        if (!call_ctrl_bit) begin
            call_kind = call_info[4] ? asp_io_pkg::ASP_CALL_WRITE_PARAMETER
                                     : asp_io_pkg::ASP_CALL_DATA_EXCHANGE;
        end else if (call_addr == `ASP_PRGM_ADDR &&
                     call_info == `ASP_PRGM_INFO) begin
            call_kind = asp_io_pkg::ASP_CALL_PROGRAM;
        end
    end

    assign dx_hit = call_valid &&
                    call_kind == asp_io_pkg::ASP_CALL_DATA_EXCHANGE &&
                    addr_hit(call_addr, call_info, ctrl_q);
    assign wp_hit = call_valid &&
                    call_kind == asp_io_pkg::ASP_CALL_WRITE_PARAMETER &&
                    addr_hit(call_addr, call_info, ctrl_q);

    // Write channel: address and data are accepted in either order.
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign aw_have  = aw_held_q || (s_axi_awvalid && s_axi_awready);
    assign w_have   = w_held_q || (s_axi_wvalid && s_axi_wready);
    assign wr_addr  = aw_held_q ? aw_addr_q : s_axi_awaddr[11:0];
    assign wr_data  = w_held_q ? w_data_q : s_axi_wdata;
    assign wr_strb  = w_held_q ? w_strb_q : s_axi_wstrb;
    assign do_write = aw_have && w_have && !s_axi_bvalid;

    // Holding registers and the write response.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            aw_held_q    <= 1'b0;
            aw_addr_q    <= 12'h000;
            w_held_q     <= 1'b0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ASP_RESP_OKAY;
        end else begin
            if (do_write) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_addr == `ASP_CTRL_ADDR) ?
                                `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr[11:0];
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_q <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // Expand byte strobes to a bit mask.
    always_comb begin
        byte_mask = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            byte_mask[i*8 +: 8] = {8{wr_strb[i]}};
        end
    end

    // Control register; the status register is read only.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `ASP_CTRL_RESET;
        end else if (do_write && wr_addr == `ASP_CTRL_ADDR) begin
            ctrl_q <= (ctrl_q & ~(byte_mask & `ASP_CTRL_WMASK)) |
                      (wr_data & byte_mask & `ASP_CTRL_WMASK);
        end
    end

    // lock is write-once: software can set it but never clear it.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lock_q <= 1'b0;
        end else if (do_write && wr_addr == `ASP_CTRL_ADDR &&
                     wr_strb[2] && wr_data[`ASP_CTRL_LOCK]) begin
            lock_q <= 1'b1;
        end
    end

    // Status word shows the block's own live state.
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`ASP_STAT_DATA_LSB +: 2]  = data_q;
        stat_word[`ASP_STAT_IN_LSB +: 2]    = in_sync;
        stat_word[`ASP_STAT_PIN_LSB]        = data_output_pin_0;
        stat_word[`ASP_STAT_PIN_LSB + 1]    = data_output_pin_1;
        stat_word[`ASP_STAT_PEND]           = pend_q;
        stat_word[`ASP_STAT_DUTY0_LSB +: 2] = duty0_q;
        stat_word[`ASP_STAT_DUTY1_LSB +: 2] = duty1_q;
    end

    // Read channel answers one cycle after the address is taken.
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `ASP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `ASP_RESP_OKAY;
            if (s_axi_araddr[11:0] == `ASP_CTRL_ADDR) begin
                s_axi_rdata <= ctrl_q | {15'h0000, lock_q, 16'h0000};
            end else if (s_axi_araddr[11:0] == `ASP_STAT_ADDR) begin
                s_axi_rdata <= stat_word;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `ASP_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Input pins are asynchronous and pass two flip-flops first.
    asp_in_sync u_sync (
        .mclk     (mclk),
        .resetn   (resetn),
        .pin_in   ({data_input_pin_3, data_input_pin_2}),
        .sync_out (in_sync)
    );

    // upper bits dropped; bit mapping; update at the end bit.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            data_q <= `ASP_DATA_RESET;
        end else if (dx_hit) begin
            data_q <= call_info[1:0];
        end
    end

    // response layout; inversion; sample at the end bit.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            resp_valid <= 1'b0;
            resp_info  <= 4'h0;
            resp_dx_q  <= 1'b0;
        end else begin
            resp_valid <= dx_hit || wp_hit;
            resp_dx_q  <= dx_hit;
            if (dx_hit) begin
                resp_info <= {in_sync[1] ^ inv_in, in_sync[0] ^ inv_in, 2'h0};
            end else if (wp_hit) begin
                resp_info <= call_info[3:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prog_mode_pulse <= 1'b0;
        end else begin
            prog_mode_pulse <= call_valid && !lock_q &&
                               call_kind == asp_io_pkg::ASP_CALL_PROGRAM;
        end
    end

    // parameter call stored only while PWM is enabled.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pend_q      <= 1'b0;
            pend_sel_q  <= 1'b0;
            pend_duty_q <= `ASP_DUTY_FULL;
        end else if (wp_hit && pwm_en) begin
            pend_q      <= 1'b1;
            pend_sel_q  <= call_info[2];
            pend_duty_q <= call_info[1:0];
        end else if (resp_sent) begin
            pend_q <= 1'b0;
        end
    end

    // apply after the response; bit 2 picks the output; full.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            duty0_q <= `ASP_DUTY_FULL;
            duty1_q <= `ASP_DUTY_FULL;
        end else if (pend_q && resp_sent) begin
            if (pend_sel_q) begin
                duty1_q <= pend_duty_q;
            end else begin
                duty0_q <= pend_duty_q;
            end
        end
    end

    // free-running sixteen-slot phase at 125 Hz.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            slot_cnt_q <= 15'h0000;
            phase_q    <= 4'h0;
        end else if (slot_cnt_q == 15'(PWM_SLOT_CYCLES - 1)) begin
            slot_cnt_q <= 15'h0000;
            phase_q    <= phase_q + 4'h1;
        end else begin
            slot_cnt_q <= slot_cnt_q + 15'h0001;
        end
    end

    // Both pins share one phase so their periods stay aligned.
    asp_pwm_chan u_chan0 (
        .mclk     (mclk),
        .resetn   (resetn),
        .pwm_en   (pwm_en),
        .duty     (duty0_q),
        .phase    (phase_q),
        .data_bit (data_q[0]),
        .pin_q    (data_output_pin_0)
    );
    asp_pwm_chan u_chan1 (
        .mclk     (mclk),
        .resetn   (resetn),
        .pwm_en   (pwm_en),
        .duty     (duty1_q),
        .phase    (phase_q),
        .data_bit (data_q[1]),
        .pin_q    (data_output_pin_1)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence write_parameter_call_taken_s;
        wp_hit && pwm_en;
    endsequence
    sequence resp_done_s;
        pend_q && resp_sent;
    endsequence

    sel_mismatch_a: assert property (
        (call_valid && call_kind == asp_io_pkg::ASP_CALL_DATA_EXCHANGE &&
         ctrl_q[`ASP_CTRL_EXT_ADDR] &&
         (~call_info[3] != ctrl_q[`ASP_CTRL_B_SLAVE])) |=>
        ($stable(data_q) && !resp_valid))
        else $error("data exchange for other select bit was taken");
    prog_lock_a: assert property (
        (call_valid && call_kind == asp_io_pkg::ASP_CALL_PROGRAM) |=>
        (prog_mode_pulse == !$past(lock_q)))
        else $error("program mode call handled against lock flag");
    out_map_a: assert property (
        dx_hit |=> (data_q == $past(call_info[1:0])) && resp_valid)
        else $error("output bits do not follow information bits");
    resp_zero_a: assert property (
        (resp_valid && resp_dx_q) |-> (resp_info[1:0] == 2'h0))
        else $error("response low bits not zero");
    input_inv_a: assert property (
        dx_hit |=> resp_info[3:2] == ($past(in_sync) ^ {2{$past(inv_in)}}))
        else $error("response input bits wrong");
    pin_window_a: assert property (
        (dx_hit && !pwm_en) ##1 !pwm_en |->
        ##1 (data_output_pin_0 == $past(call_info[0], 2)))
        else $error("output pin did not change in window");
    pwm_off_a: assert property (
        (!pwm_en && $past(!pwm_en)) |->
        ({data_output_pin_1, data_output_pin_0} == $past(data_q)))
        else $error("output modulated while disabled");
    duty_hold_a: assert property (
        write_parameter_call_taken_s ##1 (pend_q && !resp_sent) [*2] |->
        $stable(duty0_q) && $stable(duty1_q))
        else $error("duty changed before response was sent");
    duty_apply_a: assert property (
        resp_done_s |=> (($past(pend_sel_q) ? duty1_q : duty0_q) ==
                         $past(pend_duty_q)))
        else $error("duty not applied to selected output");
    high_stays_a: assert property (
        (data_q[0] && $past(data_q[0])) |-> data_output_pin_0)
        else $error("inactive output was pulled low");
endmodule

/* File: asp_call_master.sv */
// Behavioural bus master that issues decoded calls and ends responses.
`timescale 1ns/100ps
module asp_call_master #(
    parameter int RESP_GAP = 20
) (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       go,
    input  wire logic       cb,
    input  wire logic [4:0] addr,
    input  wire logic [4:0] info,
    input  wire logic       resp_valid,
    output logic            call_valid,
    output logic            call_ctrl_bit,
    output logic      [4:0] call_addr,
    output logic      [4:0] call_info,
    output logic            resp_sent
);
    logic [5:0] gap_q;

    // A call lasts one cycle; fields then toggle so stale bits never pass.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            call_valid    <= 1'h0;
            call_ctrl_bit <= 1'h0;
            call_addr     <= 5'h00;
            call_info     <= 5'h00;
        end else if (go) begin
            call_valid    <= 1'h1;
            call_ctrl_bit <= cb;
            call_addr     <= addr;
            call_info     <= info;
        end else begin
            call_valid    <= 1'h0;
            call_ctrl_bit <= ~call_ctrl_bit;
            call_addr     <= ~call_addr;
            call_info     <= ~call_info;
        end
    end

    // response end marker
    // The response occupies the wire for RESP_GAP cycles before it ends.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gap_q     <= 6'h00;
            resp_sent <= 1'h0;
        end else begin
            resp_sent <= (gap_q == 6'h01);
            if (resp_valid)
                gap_q <= RESP_GAP[5:0];
            else if (gap_q != 6'h00)
                gap_q <= gap_q - 6'h01;
        end
    end
endmodule

/* File: tb.sv */
// Self-checking bench for the slave I/O block: registers, calls, PWM.
`include "asp_io_regs.svh"
`timescale 1ns/100ps
module tb;
    localparam int          SLOT   = 4;
    localparam int          PERIOD = 16 * SLOT;
    localparam int          LIMIT  = 5000;
    localparam logic [31:0] CTRL_A = 32'(`ASP_CTRL_ADDR);
    localparam logic [31:0] STAT_A = 32'(`ASP_STAT_ADDR);
    localparam int          SLOTS [4] = '{2, 8, 4, 16};

    logic        mclk, resetn, go, cb;
    logic [4:0]  addr, info, call_addr, call_info;
    logic        call_valid, call_ctrl_bit, resp_sent, resp_valid;
    logic [3:0]  resp_info, got_info, s_axi_wstrb;
    logic        prog_mode_pulse, data_input_pin_2, data_input_pin_3;
    logic        data_output_pin_0, data_output_pin_1, got_resp, got_prog;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_bready, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [31:0] rd_data;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, prev;
    logic [1:0]  codes [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    int          mismatches, num_checks, cycles, n;

    // Only the protection fields are tied; the design ignores them.
    asp_io_top #(.PWM_SLOT_CYCLES(SLOT)) dut (
        .mclk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .call_valid, .call_ctrl_bit,
        .call_addr, .call_info, .resp_sent, .resp_valid, .resp_info,
        .prog_mode_pulse, .data_input_pin_2, .data_input_pin_3,
        .data_output_pin_0, .data_output_pin_1);

    asp_call_master #(.RESP_GAP(20)) master (
        .mclk, .resetn, .go, .cb, .addr, .info, .resp_valid, .call_valid,
        .call_ctrl_bit, .call_addr, .call_info, .resp_sent);

    // Clock at 40 MHz.
    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end

    // A hung handshake ends the run as a failure.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string what);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, g, e);
        end
    endtask

    // Address and data are offered together and dropped once taken.
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        bit aw_ok;
        bit w_ok;
        aw_ok = 0;
        w_ok = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge mclk);
            if (!aw_ok && s_axi_awready === 1'h1) begin
                aw_ok = 1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w_ok && s_axi_wready === 1'h1) begin
                w_ok = 1;
                s_axi_wvalid <= 1'h0;
            end
        end
        s_axi_bready <= 1'h1;
        do @(posedge mclk); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk(32'(s_axi_bresp), 32'(er), "bresp");
    endtask

    task automatic rd(input logic [31:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge mclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        s_axi_rready  <= 1'h1;
        do @(posedge mclk); while (s_axi_rvalid !== 1'h1);
        s_axi_rready  <= 1'h0;
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
    endtask

    // One call through the master, watching the answer for four edges.
    task automatic send(input logic c, input logic [4:0] a,
                        input logic [4:0] i);
        go   <= 1'h1;
        cb   <= c;
        addr <= a;
        info <= i;
        @(posedge mclk);
        go <= 1'h0;
        got_resp = 1'h0;
        got_prog = 1'h0;
        repeat (4) begin
            @(posedge mclk);
            if (resp_valid === 1'h1) begin
                got_resp = 1'h1;
                got_info = resp_info;
            end
            if (prog_mode_pulse === 1'h1)
                got_prog = 1'h1;
        end
    endtask

    // Any full period holds the same number of low cycles.
    task automatic count_low(input logic sel);
        n = 0;
        repeat (PERIOD) begin
            @(posedge mclk);
            if ((sel ? data_output_pin_1 : data_output_pin_0) === 1'h0)
                n++;
        end
    endtask

    // Main sequence.
    initial begin
        {resetn, go, cb, addr, info, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_arvalid, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h0F;
        {data_input_pin_2, data_input_pin_3} = 2'h0;
        repeat (4) @(posedge mclk);
        resetn <= 1'h1;
        @(posedge mclk);
        rd(STAT_A);
        chk(32'(rd_data[11:8]), 32'hF, "reset duties");
        rd(32'h0000_0010);
        chk(rd_data, 32'h0, "unmapped data");
        chk(32'(rd_resp), 32'(`ASP_RESP_SLVERR), "unmapped resp");
        axi_wr(STAT_A, 32'h0000_0000, `ASP_RESP_SLVERR);
        data_input_pin_2 <= 1'h1;
        axi_wr(CTRL_A, 32'h0000_0500, `ASP_RESP_OKAY);
        send(1'h0, 5'h05, 5'h0E);
        chk(32'(got_info), 32'h4, "dex resp");
        chk(32'(data_output_pin_0), 32'h0, "pin0 low");
        chk(32'(data_output_pin_1), 32'h1, "pin1 high");
        send(1'h0, 5'h05, 5'h01);
        chk(32'({data_output_pin_1, data_output_pin_0}), 32'h1, "pins");
        send(1'h0, 5'h06, 5'h00);
        chk(32'(got_resp), 32'h0, "foreign address");
        axi_wr(CTRL_A, 32'h0000_0502, `ASP_RESP_OKAY);
        send(1'h0, 5'h05, 5'h00);
        chk(32'(got_info), 32'h8, "inverted inputs");
        send(1'h0, 5'h05, 5'h10);
        repeat (30) @(posedge mclk);
        rd(STAT_A);
        chk(32'(rd_data[9:8]), 32'h3, "duty kept");
        count_low(1'h0);
        chk(32'(n), 32'(PERIOD), "steady low");
        axi_wr(CTRL_A, 32'h0000_0501, `ASP_RESP_OKAY);
        prev = 2'h3;
        foreach (codes[k]) begin
            send(1'h0, 5'h05, {3'h4, codes[k]});
            rd(STAT_A);
            chk(32'(rd_data[9:8]), 32'(prev), "duty before end");
            repeat (30) @(posedge mclk);
            count_low(1'h0);
            chk(32'(n), 32'(SLOTS[codes[k]] * SLOT), "low cycles");
            prev = codes[k];
        end
        send(1'h0, 5'h05, 5'h15);
        repeat (30) @(posedge mclk);
        count_low(1'h1);
        chk(32'(n), 32'(8 * SLOT), "output 1 duty");
        send(1'h0, 5'h05, 5'h03);
        count_low(1'h0);
        chk(32'(n), 32'h0, "inactive stays high");
        axi_wr(CTRL_A, 32'h0000_050D, `ASP_RESP_OKAY);
        send(1'h0, 5'h05, 5'h00);
        chk(32'(got_resp), 32'h1, "B select");
        send(1'h0, 5'h05, 5'h08);
        chk(32'(got_resp), 32'h0, "A select");
        send(1'h1, `ASP_PRGM_ADDR, `ASP_PRGM_INFO);
        chk(32'(got_prog), 32'h1, "program open");
        s_axi_wstrb <= 4'h3;
        axi_wr(CTRL_A, 32'h0001_0500, `ASP_RESP_OKAY);
        send(1'h1, `ASP_PRGM_ADDR, `ASP_PRGM_INFO);
        chk(32'(got_prog), 32'h1, "lock lane off");
        s_axi_wstrb <= 4'hF;
        axi_wr(CTRL_A, 32'h0001_0500, `ASP_RESP_OKAY);
        send(1'h1, `ASP_PRGM_ADDR, `ASP_PRGM_INFO);
        chk(32'(got_prog), 32'h0, "program locked");
        tally_and_finish();
    end
endmodule
